//--- hdl/avis_consts.svh
`ifndef AVIS_CONSTS_SVH
`define AVIS_CONSTS_SVH

// ----------------------------------------
// register indexes (byte address = 4 * index)
// ----------------------------------------
`define AVIS_IDX_ADC_CTRL 8'h0F
`define AVIS_IDX_LGAIN 8'h10
`define AVIS_IDX_RGAIN 8'h11
`define AVIS_IDX_STATUS 8'h12
`define AVIS_IDX_IRQ_EN 8'h20
`define AVIS_IDX_POL 8'h21
`define AVIS_IDX_IRQ_STAT 8'h22
`define AVIS_IDX_IRQ_CLR 8'h23

// ----------------------------------------
// field positions and widths
// ----------------------------------------
`define AVIS_NEGATE_BIT 0
`define AVIS_COMMIT_BIT 8
`define AVIS_IRQ_BIT 12
`define AVIS_GAIN_W 8
`define AVIS_EV_W 12
`define AVIS_SAMPLE_W 24
`define AVIS_ADDR_W 10

// ----------------------------------------
// reset values
// ----------------------------------------
`define AVIS_GAIN_RST 8'hC0
`define AVIS_POL_RST 12'hFFF
`define AVIS_EN_RST 12'h000

`endif

//--- hdl/avis_pkg.sv
`default_nettype none
`include "avis_consts.svh"

package avis_pkg;

  // ----------------------------------------
  // whole state of the register bank
  // ----------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [`AVIS_GAIN_W-1:0] hold_l;
    logic [`AVIS_GAIN_W-1:0] hold_r;
    logic [`AVIS_GAIN_W-1:0] act_l;
    logic [`AVIS_GAIN_W-1:0] act_r;
    logic negate;
    logic [`AVIS_EV_W-1:0] pol;
    logic [`AVIS_EV_W-1:0] en;
    logic [`AVIS_EV_W-1:0] flags;
    logic [`AVIS_EV_W-1:0] prev;
    logic [`AVIS_SAMPLE_W-1:0] samp;
  } avis_state_s;

endpackage : avis_pkg

`default_nettype wire

//--- hdl/avis_regs.sv
// Notes on behaviour
// - right-adc negate bit 0, reset zero, negates right samples when set
// - left gain eight bits [7:0], resets to unity code
// - right gain eight bits [7:0] in its own register, resets to unity
// - writing one to bit 8 of either gain register commits both gains together
// - status bit 12 is read-only and shows the interrupt output
// - bit 11 latches temperature-good event at its polarity, write one clears
// - bit 10 latches bias short event at its polarity, write one clears
// - bit 9 latches bias current event at its polarity, write one clears
// - bit 8 latches loop-lock event at its polarity, write one clears
// - bits 7:0 latch pin events eight to one at polarity, write one clears
`default_nettype none
`include "avis_consts.svh"

module avis_regs
  import avis_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [`AVIS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // event inputs
  input wire logic temp_good_in,
  input wire logic bias_short_in,
  input wire logic bias_current_in,
  input wire logic loop_locked_in,
  input wire logic [7:0] pin_event_in,
  // adc datapath
  input wire logic [`AVIS_SAMPLE_W-1:0] right_adc_sample_in,
  output logic [`AVIS_SAMPLE_W-1:0] right_adc_sample_out,
  output logic [`AVIS_GAIN_W-1:0] left_adc_gain_code,
  output logic [`AVIS_GAIN_W-1:0] right_adc_gain_code,
  // interrupt
  output logic irq
);

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  avis_state_s st;
  avis_state_s next_st;

  logic [7:0] idx;
  logic req;
  logic wr_acc;
  logic commit;
  logic [`AVIS_EV_W-1:0] ev_in;
  logic [`AVIS_EV_W-1:0] ev;
  logic [`AVIS_EV_W-1:0] clr;

  assign idx = avs_address[`AVIS_ADDR_W-1:2];
  assign req = avs_read | avs_write;
  // one wait cycle per access: readdata is captured in it
  assign avs_waitrequest = req & ~st.ack;
  assign wr_acc = avs_write & st.ack;
  assign ev_in = {temp_good_in, bias_short_in, bias_current_in, loop_locked_in, pin_event_in};
  assign commit = wr_acc & avs_byteenable[1] & avs_writedata[`AVIS_COMMIT_BIT]
    & (idx == `AVIS_IDX_LGAIN || idx == `AVIS_IDX_RGAIN);
  assign irq = |(st.flags & st.en);
  assign avs_readdata = st.rdata;
  assign right_adc_sample_out = st.samp;
  assign left_adc_gain_code = st.act_l;
  assign right_adc_gain_code = st.act_r;

  // ----------------------------------------
  // event detect: entry into the selected level
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `AVIS_EV_W; g++) begin : g_ev
      // polarity 1 catches a rise, 0 a fall
      assign ev[g] = (ev_in[g] == st.pol[g]) && (st.prev[g] != st.pol[g]);
      // either the status word itself or the clear register clears a flag
      assign clr[g] = wr_acc && avs_byteenable[g / 8] && avs_writedata[g]
        && (idx == `AVIS_IDX_STATUS || idx == `AVIS_IDX_IRQ_CLR);
    end
  endgenerate

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.ack = req & ~st.ack;
    next_st.prev = ev_in;
    // a plain negate wraps the most negative code; acceptable for audio
    if (st.negate) begin
      next_st.samp = -right_adc_sample_in;
    end else begin
      next_st.samp = right_adc_sample_in;
    end
    // set beats clear in the same cycle
    next_st.flags = (st.flags & ~clr) | ev;
    if (avs_read & ~st.ack) begin
      unique case (idx)
        `AVIS_IDX_ADC_CTRL: next_st.rdata = {31'h0, st.negate};
        `AVIS_IDX_LGAIN: next_st.rdata = {24'h0, st.hold_l};
        `AVIS_IDX_RGAIN: next_st.rdata = {24'h0, st.hold_r};
        `AVIS_IDX_STATUS: next_st.rdata = {19'h0, irq, st.flags};
        `AVIS_IDX_IRQ_EN: next_st.rdata = {20'h0, st.en};
        `AVIS_IDX_POL: next_st.rdata = {20'h0, st.pol};
        `AVIS_IDX_IRQ_STAT: next_st.rdata = {20'h0, st.flags};
        default: next_st.rdata = 32'h0;
      endcase
    end
    if (wr_acc) begin
      unique case (idx)
        `AVIS_IDX_ADC_CTRL: begin
          if (avs_byteenable[0]) begin
            next_st.negate = avs_writedata[`AVIS_NEGATE_BIT];
          end
        end
        `AVIS_IDX_LGAIN: begin
          if (avs_byteenable[0]) begin
            next_st.hold_l = avs_writedata[`AVIS_GAIN_W-1:0];
          end
        end
        `AVIS_IDX_RGAIN: begin
          if (avs_byteenable[0]) begin
            next_st.hold_r = avs_writedata[`AVIS_GAIN_W-1:0];
          end
        end
        `AVIS_IDX_IRQ_EN: begin
          if (avs_byteenable[0]) begin
            next_st.en[7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            next_st.en[11:8] = avs_writedata[11:8];
          end
        end
        `AVIS_IDX_POL: begin
          if (avs_byteenable[0]) begin
            next_st.pol[7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1]) begin
            next_st.pol[11:8] = avs_writedata[11:8];
          end
        end
        default: begin
        end
      endcase
    end
    // commit takes the holding value including this very write
    if (commit) begin
      next_st.act_l = next_st.hold_l;
      next_st.act_r = next_st.hold_r;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st <= '0;
      st.hold_l <= `AVIS_GAIN_RST;
      st.hold_r <= `AVIS_GAIN_RST;
      st.act_l <= `AVIS_GAIN_RST;
      st.act_r <= `AVIS_GAIN_RST;
      st.pol <= `AVIS_POL_RST;
      st.en <= `AVIS_EN_RST;
      st.prev <= `AVIS_POL_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_negate_sample: assert property (
    st.negate |=> right_adc_sample_out == -$past(right_adc_sample_in)
  ) else $error("right sample not negated");

  a_pass_sample: assert property (
    !st.negate |=> right_adc_sample_out == $past(right_adc_sample_in)
  ) else $error("right sample altered");

  a_left_reset: assert property (
    $rose(reset_n) |-> left_adc_gain_code == `AVIS_GAIN_RST && st.hold_l == `AVIS_GAIN_RST
  ) else $error("left gain not unity after reset");

  a_right_reset: assert property (
    $rose(reset_n) |-> right_adc_gain_code == `AVIS_GAIN_RST && !st.negate
  ) else $error("right gain or negate wrong after reset");

  a_commit_both: assert property (
    commit |=> left_adc_gain_code == st.hold_l && right_adc_gain_code == st.hold_r
  ) else $error("gains not committed together");

  a_hold_gains: assert property (
    !commit |=> $stable(left_adc_gain_code) && $stable(right_adc_gain_code)
  ) else $error("gain changed without commit");

  a_irq_readback: assert property (
    avs_read && !st.ack && idx == `AVIS_IDX_STATUS |=> avs_readdata[`AVIS_IRQ_BIT] == $past(irq)
  ) else $error("status bit 12 does not show irq");

  a_temp_latch: assert property (
    ev[11] |=> st.flags[11]
  ) else $error("temperature flag not latched");

  a_short_latch: assert property (
    st.flags[10] && !clr[10] |=> st.flags[10]
  ) else $error("bias short flag dropped without clear");

  a_current_latch: assert property (
    ev[9] |=> st.flags[9]
  ) else $error("bias current flag not latched");

  a_lock_clear: assert property (
    clr[8] && !ev[8] |=> !st.flags[8]
  ) else $error("loop lock flag not cleared");

  a_pin_latch: assert property (
    |ev[7:0] |=> (st.flags[7:0] & $past(ev[7:0])) == $past(ev[7:0])
  ) else $error("pin event not latched");

  a_negate_write: assert property (
    wr_acc && idx == `AVIS_IDX_ADC_CTRL && avs_byteenable[0]
    |=> st.negate == $past(avs_writedata[`AVIS_NEGATE_BIT])
  ) else $error("negate bit not written");

  a_negate_readback: assert property (
    avs_read && !st.ack && idx == `AVIS_IDX_ADC_CTRL
    |=> avs_readdata == {31'h0, $past(st.negate)}
  ) else $error("negate bit readback wrong");

  a_left_readback: assert property (
    avs_read && !st.ack && idx == `AVIS_IDX_LGAIN
    |=> avs_readdata == {24'h0, $past(st.hold_l)}
  ) else $error("left gain readback wrong");

  a_right_readback: assert property (
    avs_read && !st.ack && idx == `AVIS_IDX_RGAIN
    |=> avs_readdata == {24'h0, $past(st.hold_r)}
  ) else $error("right gain readback wrong");

  a_commit_left: assert property (
    commit && idx == `AVIS_IDX_LGAIN && avs_byteenable[0]
    |=> left_adc_gain_code == $past(avs_writedata[`AVIS_GAIN_W-1:0])
  ) else $error("left commit missed its own write");

  a_commit_right: assert property (
    commit && idx == `AVIS_IDX_RGAIN && avs_byteenable[0]
    |=> right_adc_gain_code == $past(avs_writedata[`AVIS_GAIN_W-1:0])
  ) else $error("right commit missed its own write");

  a_hold_left: assert property (
    wr_acc && idx == `AVIS_IDX_LGAIN && avs_byteenable[0]
    |=> st.hold_l == $past(avs_writedata[`AVIS_GAIN_W-1:0])
  ) else $error("left holding gain not written");

  a_hold_right: assert property (
    wr_acc && idx == `AVIS_IDX_RGAIN && avs_byteenable[0]
    |=> st.hold_r == $past(avs_writedata[`AVIS_GAIN_W-1:0])
  ) else $error("right holding gain not written");

  a_wait_once: assert property (
    req && !st.ack |=> !avs_waitrequest
  ) else $error("more than one wait cycle");

  a_clear_reads_zero: assert property (
    avs_read && !st.ack && idx == `AVIS_IDX_IRQ_CLR |=> avs_readdata == '0
  ) else $error("clear register does not read zero");

  a_temp_clear: assert property (
    clr[11] && !ev[11] |=> !st.flags[11]
  ) else $error("temperature flag not cleared");

  a_short_set: assert property (
    ev[10] |=> st.flags[10]
  ) else $error("bias short flag not latched");

  a_current_hold: assert property (
    st.flags[9] && !clr[9] |=> st.flags[9]
  ) else $error("bias current flag dropped without clear");

  a_lock_latch: assert property (
    ev[8] |=> st.flags[8]
  ) else $error("loop lock flag not latched");

  a_pin_clear: assert property (
    |clr[7:0] |=> (st.flags[7:0] & $past(clr[7:0] & ~ev[7:0])) == '0
  ) else $error("pin flag not cleared");

  a_no_spurious: assert property (
    (st.flags & ~$past(st.flags) & ~$past(ev)) == '0
  ) else $error("flag set without an event");

  c_flag_clear: cover property (|(clr & st.flags));
  c_commit: cover property (commit);
  c_irq_rise: cover property ($rose(irq));
  c_clear_race: cover property (|(clr & ev));
  c_negate: cover property (st.negate && right_adc_sample_in != '0);

endmodule : avis_regs

`default_nettype wire

//--- tb/adc_volume_and_irq_status_tb_top.sv
`default_nettype none
`include "avis_consts.svh"

module adc_volume_and_irq_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] ev = '0;
  logic [23:0] samp_in = '0;
  logic [23:0] samp_out;
  logic [7:0] lcode;
  logic [7:0] rcode;
  logic irq;
  logic [31:0] rd;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  avis_regs dut (
    .core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .temp_good_in(ev[11]), .bias_short_in(ev[10]), .bias_current_in(ev[9]),
    .loop_locked_in(ev[8]), .pin_event_in(ev[7:0]), .right_adc_sample_in(samp_in),
    .right_adc_sample_out(samp_out), .left_adc_gain_code(lcode),
    .right_adc_gain_code(rcode), .irq(irq)
  );

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // hang guard: whole run needs well under 20000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask : chk

  // request held until waitrequest is sampled low at a rising edge; one idle
  // edge follows so the next call never reassigns a strobe in the same step
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    bus(0, `AVIS_IDX_LGAIN, 0);
    chk("left gain rst", 32'h0000_00C0, rd);
    bus(0, `AVIS_IDX_RGAIN, 0);
    chk("right gain rst", 32'h0000_00C0, rd);
    bus(0, `AVIS_IDX_ADC_CTRL, 0);
    chk("negate rst", 32'h0, rd);
    bus(0, `AVIS_IDX_STATUS, 0);
    chk("status rst", 32'h0, rd);
    bus(0, 8'h3F, 0);
    chk("unmapped read", 32'h0, rd);
    chk("active gains rst", 32'h0000_C0C0, {16'h0, lcode, rcode});
    $display("test reset done");
  endtask : t_reset

  // every gain write keeps the reserved bits 15:9 at zero
  task automatic t_gain;
    bus(1, `AVIS_IDX_LGAIN, 32'h0000_0012);
    cyc(2);
    chk("gain before commit", 32'h0000_C0C0, {16'h0, lcode, rcode});
    bus(0, `AVIS_IDX_LGAIN, 0);
    chk("left holding", 32'h0000_0012, rd);
    bus(1, `AVIS_IDX_RGAIN, 32'h0000_0134);
    cyc(2);
    chk("both committed", 32'h0000_1234, {16'h0, lcode, rcode});
    bus(1, `AVIS_IDX_RGAIN, 32'h0000_0056);
    bus(1, `AVIS_IDX_LGAIN, 32'h0000_01FF);
    cyc(2);
    chk("commit from left", 32'h0000_FF56, {16'h0, lcode, rcode});
    bus(0, `AVIS_IDX_RGAIN, 0);
    chk("right holding", 32'h0000_0056, rd);
    $display("test gain done");
  endtask : t_gain

  task automatic t_negate;
    samp_in <= 24'h000005;
    bus(1, `AVIS_IDX_ADC_CTRL, 32'h1);
    bus(0, `AVIS_IDX_ADC_CTRL, 0);
    chk("negate readback", 32'h1, rd);
    cyc(2);
    chk("negated sample", 32'h00FF_FFFB, {8'h0, samp_out});
    bus(1, `AVIS_IDX_ADC_CTRL, 32'h0);
    cyc(2);
    chk("plain sample", 32'h0000_0005, {8'h0, samp_out});
    $display("test negate done");
  endtask : t_negate

  task automatic t_events;
    bus(1, `AVIS_IDX_IRQ_EN, 32'h0FFF);
    bus(0, `AVIS_IDX_IRQ_EN, 0);
    chk("enable readback", 32'h0000_0FFF, rd);
    // one input high at a time; the previous one falls, which rising polarity ignores
    for (int i = 0; i < 12; i++) begin
      ev <= 12'h001 << i;
      cyc(3);
      bus(0, `AVIS_IDX_STATUS, 0);
      chk("flag set", 32'h1000 | (32'h1 << i), rd);
      chk("irq high", 32'h1, {31'h0, irq});
      bus(1, `AVIS_IDX_STATUS, 32'h1 << i);
      cyc(2);
      bus(0, `AVIS_IDX_STATUS, 0);
      chk("flag cleared", 32'h0, rd);
    end
    // falling polarity with interrupts masked: flags latch, irq stays low
    bus(1, `AVIS_IDX_IRQ_EN, 32'h0);
    bus(1, `AVIS_IDX_POL, 32'h0);
    bus(0, `AVIS_IDX_POL, 0);
    chk("polarity readback", 32'h0, rd);
    ev <= 12'hFFF;
    cyc(3);
    bus(0, `AVIS_IDX_STATUS, 0);
    chk("no rising event", 32'h0, rd);
    ev <= 12'h000;
    cyc(3);
    bus(0, `AVIS_IDX_STATUS, 0);
    chk("falling events", 32'h0FFF, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(0, `AVIS_IDX_IRQ_STAT, 0);
    chk("irq status copy", 32'h0FFF, rd);
    bus(1, `AVIS_IDX_IRQ_CLR, 32'h0FFF);
    bus(0, `AVIS_IDX_IRQ_CLR, 0);
    chk("clear reads zero", 32'h0, rd);
    bus(0, `AVIS_IDX_IRQ_STAT, 0);
    chk("all cleared", 32'h0, rd);
    $display("test events done");
  endtask : t_events

  initial begin
    cyc(6);
    reset_n <= 1'b1;
    cyc(1);
    t_reset();
    t_gain();
    t_negate();
    t_events();
    complete_run();
  end

endmodule : adc_volume_and_irq_status_tb_top

`default_nettype wire
